// ### shared/twsp_regs.svh
// Register indices, field positions, reset values and counts of the three-wire serial port.
// Assumes an APB slave where each register takes one word at byte address four times its index.
`ifndef TWSP_REGS_SVH
`define TWSP_REGS_SVH

`define TWSP_IDX_MODE      16'hff80
`define TWSP_IDX_CSEL      16'hff81
`define TWSP_IDX_SHIFT     16'hff82
`define TWSP_IDX_TBUF      16'hff83

`define TWSP_MODE_EN       7
`define TWSP_MODE_TRMD     6
`define TWSP_MODE_DIR      4
`define TWSP_MODE_FLAG     0

`define TWSP_CSEL_CKP      4
`define TWSP_CSEL_DAP      3
`define TWSP_CSEL_CKS_HI   2
`define TWSP_CSEL_CKS_LO   0

`define TWSP_MODE_RST      3'h0
`define TWSP_CSEL_RST      5'h00
`define TWSP_SHIFT_RST     8'h00
`define TWSP_TBUF_RST      8'h00

`define TWSP_CKS_SLAVE     3'h7
`define TWSP_LAST_TICK     4'hf
`define TWSP_DIV_UNIT      7'h01

`endif

// ### shared/twsp_pkg.sv
// Types shared by the three-wire serial port design files.
// Assumes the constants of twsp_regs.svh for field positions.
package twsp_pkg;

    typedef enum logic [1:0] {
        TWSP_IDLE  = 2'b01,
        TWSP_SHIFT = 2'b10
    } twsp_state_t;

    typedef struct packed {
        logic port_enable;
        logic tx_rx_mode;
        logic first_bit_select;
    } twsp_mode_t;

    typedef struct packed {
        logic       clock_polarity;
        logic       data_phase;
        logic [2:0] clock_select;
    } twsp_csel_t;

endpackage

// ### rtl/twsp_clkdiv.sv
// Serial clock divider: one-cycle enable pulse every half period of the master serial clock.
// Assumes i_run is held high for the whole transfer; the count restarts while it is low.
`timescale 1ns/1ps
`include "twsp_regs.svh"
module twsp_clkdiv (
    input  wire logic       i_clk,    // System clock.
    input  wire logic       i_rst_n,  // Synchronous reset, active low.
    input  wire logic       i_run,    // Transfer in progress.
    input  wire logic [2:0] i_sel,    // Divider code 0..6.
    output logic            o_tick    // Half-period pulse.
);
    logic [6:0] cnt_q;
    logic [6:0] last;

    // Half period is 2**code system cycles, so the serial clock runs at fx/2**(code+1).
    assign last   = (`TWSP_DIV_UNIT << i_sel) - `TWSP_DIV_UNIT;
    assign o_tick = i_run && (cnt_q == last);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_run) begin
            cnt_q <= 7'h00;
        end else if (cnt_q == last) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_q + `TWSP_DIV_UNIT;
        end
    end
endmodule // twsp_clkdiv

// ### rtl/twsp_top.sv
// Three-wire serial port: 8-bit shift engine, mode and clock-select registers, APB slave.
// Assumes I_SCK and I_SI are synchronous to I_CLK and that software obeys the busy flag.
//
// Functional notes
// - Eight-bit shift register, parallel to serial both ways.
// - Reading shift word in receive mode starts transfer.
// - Input line bits shift into shift register.
// - Enable low clears shift register and busy flag.
// - Mode bit picks receive-only or transmit-and-receive.
// - Output line held low in receive-only mode.
// - First-bit select: MSB first or LSB first.
// - Busy flag high during transfer, else low.
// - Busy flag is read-only to software.
// - Clock codes divide by 2..128; seven is slave.
// - Polarity and phase bits pick four timing types.
// - Reset leaves timing type one selected.
// - Buffer write in transmit mode starts transfer.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "twsp_regs.svh"
module twsp_top (
    input  wire logic        I_CLK,      // System clock, the divider source.
    input  wire logic        I_RST_N,    // Synchronous reset, active low.
    input  wire logic        I_PSEL,     // APB select.
    input  wire logic        I_PENABLE,  // APB access phase.
    input  wire logic        I_PWRITE,   // APB direction, high for write.
    input  wire logic [31:0] I_PADDR,    // APB byte address.
    input  wire logic [31:0] I_PWDATA,   // APB write data.
    output logic      [31:0] O_PRDATA,   // APB read data.
    output logic             O_PREADY,   // APB ready.
    output logic             O_PSLVERR,  // APB error on unmapped address.
    input  wire logic        I_SCK,      // Serial clock line in, slave mode.
    input  wire logic        I_SI,       // Serial input line.
    output logic             O_SCK,      // Serial clock line out.
    output logic             O_SCK_OE,   // Serial clock drive enable.
    output logic             O_SO        // Serial output line.
);
    twsp_pkg::twsp_mode_t  mode_q;
    twsp_pkg::twsp_csel_t  csel_q;
    twsp_pkg::twsp_state_t state_q;
    logic [7:0]            tbuf_q;
    logic [7:0]            shift_q;
    logic [3:0]            tick_cnt_q;
    logic                  sck_in_q;
    logic                  sck_q;
    logic                  sck_oe_q;
    logic                  so_q;
    logic [31:0]           prdata_q;
    logic                  pready_q;
    logic                  pslverr_q;

    logic        setup;
    logic        wr_done;
    logic        rd_done;
    logic        hit_mode;
    logic        hit_csel;
    logic        hit_shift;
    logic        hit_tbuf;
    logic [31:0] rd_mux;
    logic        busy;
    logic        master;
    logic        div_tick;
    logic        tick;
    logic        odd;
    logic        drive_evt;
    logic        sample_evt;
    logic        start_tx;
    logic        start_rx;

    function automatic logic addr_hit(input logic [31:0] addr, input logic [15:0] idx);
        return addr == {14'h0000, idx, 2'b00};
    endfunction

    function automatic logic top_bit(input logic [7:0] sh, input logic lsb_first);
        return lsb_first ? sh[0] : sh[7];
    endfunction

    assign setup     = I_PSEL && !I_PENABLE;
    assign wr_done   = I_PSEL && I_PENABLE && pready_q && I_PWRITE;
    assign rd_done   = I_PSEL && I_PENABLE && pready_q && !I_PWRITE;
    assign hit_mode  = addr_hit(I_PADDR, `TWSP_IDX_MODE);
    assign hit_csel  = addr_hit(I_PADDR, `TWSP_IDX_CSEL);
    assign hit_shift = addr_hit(I_PADDR, `TWSP_IDX_SHIFT);
    assign hit_tbuf  = addr_hit(I_PADDR, `TWSP_IDX_TBUF);

    assign busy   = (state_q == twsp_pkg::TWSP_SHIFT);
    assign master = (csel_q.clock_select != `TWSP_CKS_SLAVE);

    assign start_tx = wr_done && hit_tbuf && mode_q.port_enable
                      && mode_q.tx_rx_mode && !busy;
    assign start_rx = rd_done && hit_shift && mode_q.port_enable
                      && !mode_q.tx_rx_mode && !busy;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_mode) begin
            rd_mux[`TWSP_MODE_EN]   = mode_q.port_enable;
            rd_mux[`TWSP_MODE_TRMD] = mode_q.tx_rx_mode;
            rd_mux[`TWSP_MODE_DIR]  = mode_q.first_bit_select;
            rd_mux[`TWSP_MODE_FLAG] = busy;
        end else if (hit_csel) begin
            rd_mux[`TWSP_CSEL_CKP:`TWSP_CSEL_CKS_LO] = csel_q;
        end else if (hit_shift) begin
            rd_mux[7:0] = shift_q;
        end else if (hit_tbuf) begin
            rd_mux[7:0] = tbuf_q;
        end
    end

    // Zero-wait slave: ready rises in the first access cycle, read data is latched at setup.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !(hit_mode || hit_csel || hit_shift || hit_tbuf);
            if (setup) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // The flag bit of the mode word is never taken from write data.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            mode_q <= `TWSP_MODE_RST;
        end else if (wr_done && hit_mode) begin
            mode_q.port_enable      <= I_PWDATA[`TWSP_MODE_EN];
            mode_q.tx_rx_mode       <= I_PWDATA[`TWSP_MODE_TRMD];
            mode_q.first_bit_select <= I_PWDATA[`TWSP_MODE_DIR];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            csel_q <= `TWSP_CSEL_RST;
        end else if (wr_done && hit_csel) begin
            csel_q <= I_PWDATA[`TWSP_CSEL_CKP:`TWSP_CSEL_CKS_LO];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            tbuf_q <= `TWSP_TBUF_RST;
        end else if (wr_done && hit_tbuf && !busy) begin
            tbuf_q <= I_PWDATA[7:0];
        end
    end

    twsp_clkdiv u_div (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_run   (busy && master),
        .i_sel   (csel_q.clock_select),
        .o_tick  (div_tick)
    );

    // In slave mode every edge of the outside clock counts as one half period.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            sck_in_q <= 1'b1;
        end else begin
            sck_in_q <= I_SCK;
        end
    end

    assign tick = busy && (master ? div_tick : (I_SCK != sck_in_q));
    assign odd  = tick_cnt_q[0];
    // Even ticks are the leading edge, which is falling for polarity 0.
    assign drive_evt  = tick && (csel_q.data_phase
                        ? (odd && tick_cnt_q != `TWSP_LAST_TICK) : !odd);
    assign sample_evt = tick && (csel_q.data_phase ? !odd : odd);

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || !mode_q.port_enable) begin
            state_q <= twsp_pkg::TWSP_IDLE;
        end else if (start_tx || start_rx) begin
            state_q <= twsp_pkg::TWSP_SHIFT;
        end else if (tick && tick_cnt_q == `TWSP_LAST_TICK) begin
            state_q <= twsp_pkg::TWSP_IDLE;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || !busy) begin
            tick_cnt_q <= 4'h0;
        end else if (tick) begin
            tick_cnt_q <= tick_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || !mode_q.port_enable) begin
            shift_q <= `TWSP_SHIFT_RST;
        end else if (start_tx) begin
            shift_q <= I_PWDATA[7:0];
        end else if (sample_evt) begin
            shift_q <= mode_q.first_bit_select
                       ? {I_SI, shift_q[7:1]} : {shift_q[6:0], I_SI};
        end
    end

    // With phase 1 the first bit must stand before the first edge, so it is launched at start.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || !mode_q.port_enable || !mode_q.tx_rx_mode) begin
            so_q <= 1'b0;
        end else if (start_tx && csel_q.data_phase) begin
            so_q <= top_bit(I_PWDATA[7:0], mode_q.first_bit_select);
        end else if (drive_evt) begin
            so_q <= top_bit(shift_q, mode_q.first_bit_select);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            sck_q    <= 1'b1;
            sck_oe_q <= 1'b0;
        end else begin
            sck_oe_q <= mode_q.port_enable && master;
            // Disable parks the clock at once, so an aborted word leaves no stray level.
            if (!busy || !mode_q.port_enable) begin
                sck_q <= !csel_q.clock_polarity;
            end else if (tick && master) begin
                sck_q <= !sck_q;
            end
        end
    end

    assign O_PRDATA  = prdata_q;
    assign O_PREADY  = pready_q;
    assign O_PSLVERR = pslverr_q;
    assign O_SCK     = sck_q;
    assign O_SCK_OE  = sck_oe_q;
    assign O_SO      = so_q;

    property p_rx_start;
        @(posedge I_CLK) disable iff (!I_RST_N)
        start_rx |=> busy;
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("receive did not start");

    property p_tx_start;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (wr_done && hit_tbuf && mode_q.port_enable && mode_q.tx_rx_mode && !busy)
        |=> busy ##1 (tbuf_q == $past(I_PWDATA[7:0], 2));
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("transmit did not start");

    property p_so_low;
        @(posedge I_CLK) disable iff (!I_RST_N)
        !mode_q.tx_rx_mode |=> (!O_SO || mode_q.tx_rx_mode);
    endproperty
    a_so_low: assert property (p_so_low) else $error("output line not low");

    property p_disable;
        @(posedge I_CLK) disable iff (!I_RST_N)
        !mode_q.port_enable |=> (!busy && shift_q == `TWSP_SHIFT_RST);
    endproperty
    a_disable: assert property (p_disable) else $error("disable did not clear");

    property p_flag_ro;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (wr_done && hit_mode && !busy) |=> !busy;
    endproperty
    a_flag_ro: assert property (p_flag_ro) else $error("flag written by software");

    property p_busy_len;
        @(posedge I_CLK) disable iff (!I_RST_N || !mode_q.port_enable)
        ($rose(busy) && csel_q.clock_select == 3'h0)
        |-> busy [*8] ##1 busy [*8] ##1 !busy;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("transfer length wrong");

    property p_sck_idle;
        @(posedge I_CLK) disable iff (!I_RST_N)
        ($fell(busy) && master) |-> (O_SCK == !csel_q.clock_polarity);
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("clock not idle after word");

    property p_reset_type;
        @(posedge I_CLK)
        $rose(I_RST_N) |-> (csel_q == `TWSP_CSEL_RST && O_SCK);
    endproperty
    a_reset_type: assert property (p_reset_type) else $error("timing type not 1");

    property p_slave_oe;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (csel_q.clock_select == `TWSP_CKS_SLAVE) |=> !O_SCK_OE;
    endproperty
    a_slave_oe: assert property (p_slave_oe) else $error("clock driven in slave");
endmodule // twsp_top

// ### test/twsp_peer.sv
// Behavioural peer chip on the three serial lines, all four timing types.
// Assumes the bench frames each word with i_sel and sets order and polarity first.
`timescale 1ns/1ps
module twsp_peer (
    input  wire logic       i_clk,   // Bench clock, measures edge spacing.
    input  wire logic       i_sel,   // Word frame.
    input  wire logic       i_ckp,   // Clock polarity.
    input  wire logic       i_dap,   // Data phase.
    input  wire logic       i_lsb,   // Low bit first.
    input  wire logic       i_sck,   // Serial clock line.
    input  wire logic       i_so,    // Data from the port.
    input  wire logic [7:0] i_tx,    // Word to send.
    output logic            o_si,    // Data to the port.
    output logic      [7:0] o_rx,    // Word received.
    output int              o_edges, // Clock edges in the frame.
    output int              o_gap    // Cycles between the last two edges.
);
    int   n;
    int   cnt;
    logic sck_d;
    initial begin
        o_si = 1'b0;
        o_rx = 8'h00;
        o_edges = 0;
        o_gap = 0;
        n = 0;
        cnt = 0;
        sck_d = 1'b1;
    end
    always @(posedge i_sel) begin
        n = 0;
        o_edges = 0;
        // With phase 1 the first bit must stand before the leading edge.
        if (i_dap) o_si = i_lsb ? i_tx[0] : i_tx[7];
    end
    // The line floats between frames; flipping it keeps a stale bit from matching.
    always @(negedge i_sel) o_si = ~o_si;
    always @(i_sck) if (i_sel) begin
        o_edges = o_edges + 1;
        if ((i_sck === i_ckp) != i_dap) begin
            if (n < 8) o_si = i_lsb ? i_tx[n] : i_tx[7-n];
        end else begin
            o_rx[i_lsb ? n : 7-n] = i_so;
            n = n + 1;
        end
    end
    always @(posedge i_clk) begin
        if (i_sck !== sck_d) begin
            o_gap <= cnt;
            cnt <= 1;
        end else begin
            cnt <= cnt + 1;
        end
        sck_d <= i_sck;
    end
endmodule // twsp_peer

// ### test/tb_top.sv
// Self-checking bench for the three-wire serial port over APB.
// Assumes twsp_top and the peer model; the run ends in test_done.
`timescale 1ns/1ps
`include "twsp_regs.svh"
module tb_top;
    localparam logic [31:0] A_MODE = 32'(`TWSP_IDX_MODE) << 2;
    localparam logic [31:0] A_CSEL = 32'(`TWSP_IDX_CSEL) << 2;
    localparam logic [31:0] A_SHFT = 32'(`TWSP_IDX_SHIFT) << 2;
    localparam logic [31:0] A_TBUF = 32'(`TWSP_IDX_TBUF) << 2;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tsck = 1'b1;
    logic        si;
    logic        sck;
    logic        oe;
    logic        so;
    logic        line;
    logic        sel = 1'b0;
    logic        ckp = 1'b0;
    logic        lsb = 1'b0;
    logic        dap = 1'b0;
    logic        rxo = 1'b0;
    logic [7:0]  ptx = 8'h00;
    logic [7:0]  prx;
    int          edges;
    int          gap;
    int          num_errors = 0;
    int          n_compared = 0;
    logic [31:0] r;
    logic        e;
    always #2 clk = ~clk;
    assign line = oe ? sck : tsck;
    twsp_top uut (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCK(tsck), .I_SI(si),
        .O_SCK(sck), .O_SCK_OE(oe), .O_SO(so));
    twsp_peer peer (.i_clk(clk), .i_sel(sel), .i_ckp(ckp), .i_dap(dap), .i_lsb(lsb),
        .i_sck(line), .i_so(so), .i_tx(ptx), .o_si(si), .o_rx(prx), .o_edges(edges),
        .o_gap(gap));

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic apb_wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, d, x, y);
    endtask
    task automatic apb_rd(input logic [31:0] a, output logic [31:0] x);
        logic y;
        apb(1'b0, a, 8'h00, x, y);
    endtask
    task automatic xfer(input logic [2:0] code, input logic cp, dp, dir, trmd,
                        input logic [7:0] tx, pw);
        logic [31:0] x;
        apb_wr(A_MODE, 8'h00);
        apb_wr(A_CSEL, {3'h0, cp, dp, code});
        apb_wr(A_MODE, {1'b1, trmd, 1'b0, dir, 4'h0});
        ckp = cp;
        dap = dp;
        // The outside clock idles at the level that the chosen polarity gives.
        tsck <= ~cp;
        lsb = dir;
        ptx = pw;
        repeat (2) @(posedge clk);
        chk("clock drive", {31'h0, oe}, {31'h0, code != 3'h7});
        if (code != 3'h7) chk("clock idle", {31'h0, sck}, {31'h0, ~cp});
        sel = 1'b1;
        rxo = ~trmd;
        if (trmd) apb_wr(A_TBUF, tx);
        else apb_rd(A_SHFT, x);
        if (code == 3'h7) repeat (16) begin
            repeat (4) @(posedge clk);
            tsck <= ~tsck;
        end
        x = 32'h1;
        while (x[0] !== 1'b0) apb_rd(A_MODE, x);
        sel = 1'b0;
        rxo = 1'b0;
        chk("edges", edges, 32'd16);
        if (code != 3'h7) chk("half period", gap, 32'h1 << code);
        // Switch to transmit mode first, so this read cannot start another word.
        apb_wr(A_MODE, {3'h6, dir, 4'h0});
        apb_rd(A_SHFT, x);
        chk("shift word", x, {24'h0, pw});
        if (trmd) chk("peer word", {24'h0, prx}, {24'h0, tx});
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) if (rxo) chk("out low", {31'h0, so}, 32'h0);

    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb_rd(A_MODE, r);
        chk("mode reset", r, 32'h0);
        apb_rd(A_CSEL, r);
        chk("csel reset", r, 32'h0);
        apb_rd(A_SHFT, r);
        chk("shift reset", r, 32'h0);
        apb(1'b0, 32'h100, 8'h00, r, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        apb_wr(A_MODE, 8'hd1);
        apb_rd(A_MODE, r);
        chk("flag read only", r, 32'hd0);
        $display("test registers done");
        for (int t = 0; t < 4; t++) begin
            apb_wr(A_MODE, 8'h00);
            apb_wr(A_CSEL, {3'h0, t[1:0], 3'h0});
            apb_rd(A_CSEL, r);
            chk("csel rw", r, {27'h0, t[1:0], 3'h0});
            apb_wr(A_MODE, 8'h80);
            repeat (2) @(posedge clk);
            chk("idle level", {31'h0, sck}, {31'h0, ~t[1]});
        end
        $display("test timing types done");
        for (int c = 0; c < 8; c++) begin
            xfer(c[2:0], c[1], c[2], c[0], (c % 3) != 0, {c[2:0], 5'h0d} ^ 8'ha6,
                 {c[2:0], 5'h13} ^ 8'h5c);
        end
        $display("test transfers done");
        apb_wr(A_MODE, 8'h00);
        apb_wr(A_CSEL, 8'h06);
        apb_wr(A_MODE, 8'hc0);
        sel = 1'b1;
        apb_wr(A_TBUF, 8'h5a);
        repeat (100) @(posedge clk);
        apb_rd(A_MODE, r);
        chk("busy flag", r, 32'hc1);
        // Only the enable bit drops, since the mode bit must not change mid-word.
        apb_wr(A_MODE, 8'h40);
        sel = 1'b0;
        apb_rd(A_MODE, r);
        chk("abort flag", r, 32'h40);
        apb_rd(A_SHFT, r);
        chk("abort shift", r, 32'h0);
        chk("abort out", {31'h0, so}, 32'h0);
        apb_wr(A_MODE, 8'h00);
        apb_wr(A_CSEL, 8'h00);
        chk("pins released", {30'h0, oe, so}, 32'h0);
        $display("test abort done");
        test_done();
    end
endmodule // tb_top
